// >>> t3cl_cfg.svh
`ifndef T3CL_CFG_SVH
`define T3CL_CFG_SVH

// ------------------------------------------------------------
// register addresses on the special-function bus
// ------------------------------------------------------------
`define T3CL_ADDR_CTRL 8'h91
`define T3CL_ADDR_RL_LO 8'h92
`define T3CL_ADDR_RL_HI 8'h93
`define T3CL_ADDR_CNT_LO 8'h94
`define T3CL_ADDR_CNT_HI 8'h95

// ------------------------------------------------------------
// control register field positions
// ------------------------------------------------------------
`define T3CL_BIT_HI_FLAG 7
`define T3CL_BIT_LO_FLAG 6
`define T3CL_BIT_LO_IRQ_EN 5
`define T3CL_BIT_CAP_EN 4
`define T3CL_BIT_SPLIT 3
`define T3CL_BIT_RUN 2
`define T3CL_XCLK_MSB 1
`define T3CL_XCLK_LSB 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define T3CL_CTRL_RESET 8'h00
`define T3CL_BYTE_RESET 8'h00

// ------------------------------------------------------------
// divider terminal counts
// ------------------------------------------------------------
`define T3CL_SYS_DIV_LAST 4'hb
`define T3CL_OSC_DIV_LAST 3'h7

`endif

// >>> t3cl_pkg.sv
package t3cl_pkg;

  typedef logic [7:0] t3cl_byte_t;

  // external clock select codes, in field order 00..11
  typedef enum logic [1:0] {
    t3cl_xclk_div12_cmp,
    t3cl_xclk_osc_osc,
    t3cl_xclk_div12_osc,
    t3cl_xclk_cmp_osc
  } t3cl_xclk_t;

endpackage

// >>> t3cl_sync_edge.sv
`timescale 1ns/1ps

module t3cl_sync_edge
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic rise
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ------------------------------------------------------------
  // two-stage synchroniser, edge taken after the second stage
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;

endmodule // t3cl_sync_edge

// >>> t3cl_timer3_control.sv
// Notes on behaviour
// - high byte wrap sets high overflow flag
// - 16-bit wrap sets high overflow flag
// - high flag requests interrupt when enabled
// - flags cleared only by software writes
// - low byte wrap always sets low flag
// - low flag interrupts when both enables set
// - capture enable bit selects capture mode
// - split select: one 16-bit or two 8-bit
// - counting needs run bit, except split low
// - split low byte counts regardless of run
// - split: shared external source, per-byte choice
// - non-system sources synchronised before use
// - select 00: system_clock/12 count, comparator trigger
// - select 01: oscillator/8 count and trigger
// - select 11: comparator count, oscillator/8 trigger
// - capture copies count to reload, sets flag
// - 16-bit wrap loads reload pair, or zero in capture mode
// - clock choice set picks system clock
`timescale 1ns/1ps
`include "t3cl_cfg.svh"

module t3cl_timer3_control
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic high_byte_clock_choice,
  input wire logic low_byte_clock_choice,
  input wire logic timer_irq_enable,
  input wire logic ext_osc_in,
  input wire logic cmp1_in,
  output logic [7:0] sfr_rdata,
  output logic timer_irq
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic at_top(input t3cl_pkg::t3cl_byte_t b);
    at_top = (b == 8'hff);
  endfunction

  function automatic logic pick_tick(input logic choice, input logic ext_tick);
    pick_tick = choice ? 1'b1 : ext_tick;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic high_overflow_flag_q;
  logic low_overflow_flag_q;
  logic low_byte_irq_enable_q;
  logic capture_mode_enable_q;
  logic split_mode_select_q;
  logic run_control_q;
  t3cl_pkg::t3cl_xclk_t ext_clock_select_q;
  t3cl_pkg::t3cl_byte_t count_low_byte_q;
  t3cl_pkg::t3cl_byte_t count_high_byte_q;
  t3cl_pkg::t3cl_byte_t reload_low_byte_q;
  t3cl_pkg::t3cl_byte_t reload_high_byte_q;
  logic [3:0] sys_div_q;
  logic [2:0] osc_div_q;
  logic [7:0] sfr_rdata_q;
  logic timer_irq_q;

  logic osc_rise;
  logic cmp_rise;
  logic div12_tick;
  logic osc8_tick;
  logic ext_tick;
  logic trig_tick;
  logic lo_tick;
  logic hi_tick;
  logic step16;
  logic wrap16;
  logic low_ovf;
  logic high_ovf;
  logic capture_evt;
  logic wr_ctrl;
  logic wr_rl_lo;
  logic wr_rl_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  t3cl_pkg::t3cl_byte_t count_low_byte_d;
  t3cl_pkg::t3cl_byte_t count_high_byte_d;

  // ------------------------------------------------------------
  // source synchronisation
  // ------------------------------------------------------------
  t3cl_sync_edge u_osc_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(ext_osc_in),
    .rise(osc_rise)
  );

  t3cl_sync_edge u_cmp_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(cmp1_in),
    .rise(cmp_rise)
  );

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sys_div_q <= 4'h0;
    else if (div12_tick)
      sys_div_q <= 4'h0;
    else
      sys_div_q <= sys_div_q + 4'h1;
  end

  // divide after sync: oscillator must stay well below half of clk
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      osc_div_q <= 3'h0;
    else if (osc_rise)
      osc_div_q <= osc_div_q + 3'h1;
  end

  assign div12_tick = (sys_div_q == `T3CL_SYS_DIV_LAST);
  assign osc8_tick = osc_rise & (osc_div_q == `T3CL_OSC_DIV_LAST);

  // ------------------------------------------------------------
  // source and trigger selection
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (ext_clock_select_q)
      t3cl_pkg::t3cl_xclk_div12_cmp:
      begin
        ext_tick = div12_tick;
        trig_tick = cmp_rise;
      end
      t3cl_pkg::t3cl_xclk_osc_osc:
      begin
        ext_tick = osc8_tick;
        trig_tick = osc8_tick;
      end
      t3cl_pkg::t3cl_xclk_div12_osc:
      begin
        ext_tick = div12_tick;
        trig_tick = osc8_tick;
      end
      t3cl_pkg::t3cl_xclk_cmp_osc:
      begin
        ext_tick = cmp_rise;
        trig_tick = osc8_tick;
      end
    endcase
  end

  // one shared external source, each byte may take system clock instead
  assign lo_tick = pick_tick(low_byte_clock_choice, ext_tick);
  assign hi_tick = pick_tick(high_byte_clock_choice, ext_tick);

  // ------------------------------------------------------------
  // counting events
  // ------------------------------------------------------------
  // 16-bit mode is clocked by the low byte choice
  assign step16 = ~split_mode_select_q & run_control_q & lo_tick;
  assign wrap16 = step16 & at_top(count_low_byte_q) & at_top(count_high_byte_q);
  assign low_ovf = split_mode_select_q ? (lo_tick & at_top(count_low_byte_q))
                                      : (step16 & at_top(count_low_byte_q));
  assign high_ovf = split_mode_select_q ? (run_control_q & hi_tick & at_top(count_high_byte_q))
                                       : wrap16;
  assign capture_evt = capture_mode_enable_q & run_control_q & trig_tick;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign wr_ctrl = sfr_wr & (sfr_addr == `T3CL_ADDR_CTRL);
  assign wr_rl_lo = sfr_wr & (sfr_addr == `T3CL_ADDR_RL_LO);
  assign wr_rl_hi = sfr_wr & (sfr_addr == `T3CL_ADDR_RL_HI);
  assign wr_cnt_lo = sfr_wr & (sfr_addr == `T3CL_ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr & (sfr_addr == `T3CL_ADDR_CNT_HI);

  // ------------------------------------------------------------
  // next count
  // ------------------------------------------------------------
  always_comb
  begin
    count_low_byte_d = count_low_byte_q;
    count_high_byte_d = count_high_byte_q;
    if (split_mode_select_q)
    begin
      if (lo_tick)
        count_low_byte_d = at_top(count_low_byte_q) ? reload_low_byte_q : count_low_byte_q + 8'h01;
      if (run_control_q & hi_tick)
        count_high_byte_d = at_top(count_high_byte_q) ? reload_high_byte_q : count_high_byte_q + 8'h01;
    end
    else if (wrap16)
    begin
      // capture mode keeps the reload pair for captures, so the count rolls to zero
      if (capture_mode_enable_q)
      begin
        count_low_byte_d = 8'h00;
        count_high_byte_d = 8'h00;
      end
      else
      begin
        count_low_byte_d = reload_low_byte_q;
        count_high_byte_d = reload_high_byte_q;
      end
    end
    else if (step16)
    begin
      {count_high_byte_d, count_low_byte_d} = {count_high_byte_q, count_low_byte_q} + 16'h0001;
    end
    if (wr_cnt_lo)
      count_low_byte_d = sfr_wdata;
    if (wr_cnt_hi)
      count_high_byte_d = sfr_wdata;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_low_byte_q <= `T3CL_BYTE_RESET;
      count_high_byte_q <= `T3CL_BYTE_RESET;
    end
    else
    begin
      count_low_byte_q <= count_low_byte_d;
      count_high_byte_q <= count_high_byte_d;
    end
  end

  // ------------------------------------------------------------
  // reload pair, capture wins over a same-cycle write
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reload_low_byte_q <= `T3CL_BYTE_RESET;
      reload_high_byte_q <= `T3CL_BYTE_RESET;
    end
    else if (capture_evt)
    begin
      reload_low_byte_q <= count_low_byte_q;
      reload_high_byte_q <= count_high_byte_q;
    end
    else
    begin
      if (wr_rl_lo)
        reload_low_byte_q <= sfr_wdata;
      if (wr_rl_hi)
        reload_high_byte_q <= sfr_wdata;
    end
  end

  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_byte_irq_enable_q <= 1'(`T3CL_CTRL_RESET >> `T3CL_BIT_LO_IRQ_EN);
      capture_mode_enable_q <= 1'(`T3CL_CTRL_RESET >> `T3CL_BIT_CAP_EN);
      split_mode_select_q <= 1'(`T3CL_CTRL_RESET >> `T3CL_BIT_SPLIT);
      run_control_q <= 1'(`T3CL_CTRL_RESET >> `T3CL_BIT_RUN);
      ext_clock_select_q <= t3cl_pkg::t3cl_xclk_t'(2'(`T3CL_CTRL_RESET));
    end
    else if (wr_ctrl)
    begin
      low_byte_irq_enable_q <= sfr_wdata[`T3CL_BIT_LO_IRQ_EN];
      capture_mode_enable_q <= sfr_wdata[`T3CL_BIT_CAP_EN];
      split_mode_select_q <= sfr_wdata[`T3CL_BIT_SPLIT];
      run_control_q <= sfr_wdata[`T3CL_BIT_RUN];
      ext_clock_select_q <= t3cl_pkg::t3cl_xclk_t'(sfr_wdata[`T3CL_XCLK_MSB:`T3CL_XCLK_LSB]);
    end
  end

  // ------------------------------------------------------------
  // overflow flags: hardware set beats software clear
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      high_overflow_flag_q <= 1'(`T3CL_CTRL_RESET >> `T3CL_BIT_HI_FLAG);
      low_overflow_flag_q <= 1'(`T3CL_CTRL_RESET >> `T3CL_BIT_LO_FLAG);
    end
    else
    begin
      high_overflow_flag_q <= (wr_ctrl ? sfr_wdata[`T3CL_BIT_HI_FLAG] : high_overflow_flag_q)
                              | high_ovf | capture_evt;
      low_overflow_flag_q <= (wr_ctrl ? sfr_wdata[`T3CL_BIT_LO_FLAG] : low_overflow_flag_q)
                             | low_ovf;
    end
  end

  // ------------------------------------------------------------
  // interrupt request, a level while a flag stands
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      timer_irq_q <= 1'b0;
    else
      timer_irq_q <= timer_irq_enable
                     & (high_overflow_flag_q
                        | (low_byte_irq_enable_q & low_overflow_flag_q));
  end

  // ------------------------------------------------------------
  // read port, registered; zero when not reading or unmapped
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sfr_rdata_q <= 8'h00;
    else if (!sfr_rd)
      sfr_rdata_q <= 8'h00;
    else
    begin
      unique case (sfr_addr)
        `T3CL_ADDR_CTRL: sfr_rdata_q <= {high_overflow_flag_q, low_overflow_flag_q, low_byte_irq_enable_q,
                                         capture_mode_enable_q, split_mode_select_q, run_control_q,
                                         ext_clock_select_q};
        `T3CL_ADDR_RL_LO: sfr_rdata_q <= reload_low_byte_q;
        `T3CL_ADDR_RL_HI: sfr_rdata_q <= reload_high_byte_q;
        `T3CL_ADDR_CNT_LO: sfr_rdata_q <= count_low_byte_q;
        `T3CL_ADDR_CNT_HI: sfr_rdata_q <= count_high_byte_q;
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = sfr_rdata_q;
  assign timer_irq = timer_irq_q;

endmodule // t3cl_timer3_control

// >>> t3cl_timer3_control_chk.sv
`timescale 1ns/1ps
// ------------------------------
// port-level checks
// ------------------------------
module t3cl_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic high_byte_clock_choice,
  input wire logic low_byte_clock_choice,
  input wire logic timer_irq_enable,
  input wire logic ext_osc_in,
  input wire logic cmp1_in,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic run_q;
  wire c_rd = sfr_rd && !sfr_wr && sfr_addr == 8'h91;
  wire c_wr = sfr_wr && sfr_addr == 8'h91;
  wire h_wr = sfr_wr && sfr_addr == 8'h95;
  wire h_rd = sfr_rd && !sfr_wr && sfr_addr == 8'h95;
  wire u_rd = sfr_rd && (sfr_addr < 8'h91 || sfr_addr > 8'h95);
  // run mirror: count hold only checked while stopped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      run_q <= 1'b0;
    else if (c_wr)
      run_q <= sfr_wdata[2];
  end
  a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property ($past(u_rd) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (c_wr ##2 c_rd |=> sfr_rdata[5:0] == 6'($past(sfr_wdata, 3)))
    else $error("control bits lost");
  a_hi_flag_sticky: assert property (c_rd ##1 (sfr_rdata[7] && !sfr_wr) ##1 c_rd |=> sfr_rdata[7])
    else $error("high flag cleared by hardware");
  a_count_hold: assert property (h_wr && !run_q ##1 !sfr_wr ##1 h_rd |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("stopped high byte moved");
  a_irq_follows: assert property (c_rd && timer_irq_enable ##1 sfr_rdata[7] && timer_irq_enable |-> timer_irq)
    else $error("high flag without interrupt");
  a_irq_low_gate: assert property (c_rd ##1 !sfr_rdata[7] && !(sfr_rdata[6] && sfr_rdata[5]) |-> !timer_irq)
    else $error("interrupt without enabled source");
  a_irq_off: assert property (!timer_irq_enable [*2] |-> !timer_irq)
    else $error("interrupt while disabled");
  c_hi_flag: cover property (c_rd ##1 sfr_rdata[7]);
  c_irq: cover property (timer_irq);
  c_split: cover property (c_wr && sfr_wdata[3]);
endmodule // t3cl_chk

bind t3cl_timer3_control t3cl_chk i_t3cl_chk
(
  .clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .high_byte_clock_choice(high_byte_clock_choice),
  .low_byte_clock_choice(low_byte_clock_choice), .timer_irq_enable(timer_irq_enable),
  .ext_osc_in(ext_osc_in), .cmp1_in(cmp1_in), .sfr_rdata(sfr_rdata), .timer_irq(timer_irq)
);

// >>> test_t3cl_timer3_control.sv
`timescale 1ns/1ps
`define T3T_CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected %0t: %h vs %h", $time, g, e); end end
module test_t3cl_timer3_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic hbc = 1'b0;
  logic lbc = 1'b0;
  logic ien = 1'b1;
  logic osc = 1'b0;
  logic cmp = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] sfr_rdata;
  logic timer_irq;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  logic [71:0] t;
  int n_fail = 0;
  int checks = 0;
  // count, reload hi, ctrl, exp ctrl, exp hi, hi mask, {hbc, lbc, ien, irq}
  localparam logic [63:0] cases [7] = '{
    {16'hfffe, 8'h12, 8'h04, 8'hc4, 8'h12, 8'hff, 8'h07},
    {16'hfffe, 8'h12, 8'h04, 8'hc4, 8'h12, 8'hff, 8'h04},
    {16'h00fe, 8'h12, 8'h04, 8'h44, 8'h01, 8'hff, 8'h06},
    {16'h00fe, 8'h12, 8'h24, 8'h64, 8'h01, 8'hff, 8'h07},
    {16'hfffe, 8'h12, 8'h00, 8'h00, 8'hff, 8'hff, 8'h06},
    {16'h50fe, 8'h12, 8'h09, 8'h49, 8'h50, 8'hff, 8'h06},
    {16'hff00, 8'h80, 8'h0d, 8'h8d, 8'h80, 8'hf0, 8'h0b}};

  always #2 clk = ~clk;

  t3cl_timer3_control i_t3cl_timer3_control
  (
    .clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .high_byte_clock_choice(hbc), .low_byte_clock_choice(lbc),
    .timer_irq_enable(ien), .ext_osc_in(osc), .cmp1_in(cmp), .sfr_rdata(sfr_rdata),
    .timer_irq(timer_irq)
  );

  // ------------------------------
  // read data is valid the cycle after the strobe
  // ------------------------------
  always @(negedge clk)
  begin
    if (rd_seen)
    begin
      e = exp_q.pop_front();
      `T3T_CHK(sfr_rdata & e[15:8], e[7:0])
    end
    rd_seen = sfr_rd;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    exp_q.push_back({m, d & m});
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
  endtask

  // pulses held two cycles or more so the synchroniser cannot miss them
  task automatic pulse(input int n, input logic o);
    repeat (n)
    begin
      osc <= o;
      cmp <= !o;
      repeat (2 + $urandom % 3) @(posedge clk);
      osc <= 1'b0;
      cmp <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic scen(input logic [63:0] c);
    hbc <= c[3];
    lbc <= c[2];
    ien <= c[1];
    wr(8'h93, c[47:40]);
    wr(8'h92, 8'h34);
    wr(8'h95, c[63:56]);
    wr(8'h94, c[55:48]);
    wr(8'h91, c[39:32]);
    repeat (4) @(posedge clk);
    rd(8'h91, c[31:24]);
    rd(8'h91, c[31:24]);
    @(negedge clk);
    `T3T_CHK(timer_irq, c[0])
    @(posedge clk);
    wr(8'h91, c[31:24] & 8'hc3);
    rd(8'h95, c[23:16], c[15:8]);
    wr(8'h91, 8'h00);
    rd(8'h91, 8'h00);
    $display("case %h done", c[39:32]);
  endtask

  task automatic ext(input logic [7:0] ct, input logic o, input int n, input logic [7:0] ec, input logic [7:0] el);
    wr(8'h93, 8'hff);
    wr(8'h95, 8'h00);
    wr(8'h94, 8'h00);
    wr(8'h91, ct);
    pulse(n, o);
    repeat (6) @(posedge clk);
    rd(8'h91, ec);
    wr(8'h91, 8'h00);
    rd(ct[4] ? 8'h93 : 8'h94, el);
    $display("source %h done", ct);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #80000;
    n_fail++;
    conclude();
  end

  initial
  begin
    void'($urandom(54));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int a = 8'h91; a < 8'h96; a++)
      rd(8'(a), 8'h00);
    t = 72'($urandom);
    wr(8'h96, t[7:0]);
    rd(8'h96, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h95, t[15:8]);
    rd(8'h95, t[15:8]);
    for (int i = 0; i < 4; i++)
    begin
      t[5:0] = {4'($urandom), 2'(i)};
      t[3] = t[3] & ~t[4];
      wr(8'h91, {2'b00, t[5:0]});
      rd(8'h91, {2'b00, t[5:0]});
    end
    wr(8'h91, 8'h00);
    $display("registers done");
    foreach (cases[i])
      scen(cases[i]);
    hbc <= 1'b0;
    lbc <= 1'b0;
    // run window of 48 edges holds exactly four divide-by-twelve ticks, whatever the phase
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h94, 8'h00);
      wr(8'h91, 8'h04 | 8'(i << 1));
      repeat (46) @(posedge clk);
      wr(8'h91, 8'h00);
      rd(8'h94, 8'h04);
      $display("divider %0d done", i);
    end
    ext(8'h07, 1'b0, 5, 8'h07, 8'h05);
    ext(8'h05, 1'b1, 16, 8'h05, 8'h02);
    lbc <= 1'b1;
    ext(8'h14, 1'b0, 1, 8'h94, 8'h00);
    ext(8'h16, 1'b1, 8, 8'h96, 8'h00);
    conclude();
  end
endmodule // test_t3cl_timer3_control
